// [hw/sbp_pkg.sv]
// Package for the six-bit port: register map, field positions, reset values.
// Assumes a 32-bit AXI4-Lite register bus with byte addressing.
`default_nettype none
package sbp_pkg;
  localparam int SBP_DATA_W = 32;
  localparam int SBP_ADDR_W = 8;
  localparam int SBP_PORT_W = 6;
  localparam int SBP_GROUP_W = 8;
  localparam int SBP_CMP_W = 2;

  // Register byte offsets
  localparam logic [SBP_ADDR_W-1:0] SBP_PIN_DATA_OFF = 8'h00;
  localparam logic [SBP_ADDR_W-1:0] SBP_PIN_DIRECTION_OFF = 8'h04;
  localparam logic [SBP_ADDR_W-1:0] SBP_PULLDOWN_OFF = 8'h08;
  localparam logic [SBP_ADDR_W-1:0] SBP_CMP_DRIVE_OFF = 8'h0c;
  localparam logic [SBP_ADDR_W-1:0] SBP_PIN_LEVEL_OFF = 8'h10;
  localparam logic [SBP_ADDR_W-1:0] SBP_OPTIONS_OFF = 8'h14;

  // Field positions inside the pulldown control register
  localparam int SBP_PD_LOWER_GRP_BIT = 6;
  localparam int SBP_PD_UPPER_GRP_BIT = 7;
  // Upper two pins can be driven by the comparators
  localparam int SBP_CMP_PIN_LO = 4;

  // Reset values
  localparam logic [SBP_PORT_W-1:0] SBP_DIRECTION_RST = 6'h00;
  localparam logic [SBP_PORT_W-1:0] SBP_PD_INHIBIT_RST = 6'h00;
  localparam logic SBP_PD_GROUP_RST = 1'b0;
  localparam logic [SBP_CMP_W-1:0] SBP_CMP_DRIVE_RST = 2'h0;

  localparam logic [1:0] SBP_RESP_OKAY = 2'h0;
  localparam logic [1:0] SBP_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SBP_SEL_NONE = 3'b000,
    SBP_SEL_DATA = 3'b001,
    SBP_SEL_DIR = 3'b010,
    SBP_SEL_PD = 3'b011,
    SBP_SEL_CMP = 3'b100,
    SBP_SEL_LEVEL = 3'b101,
    SBP_SEL_OPT = 3'b110
  } sbp_sel_t;

  typedef enum logic {
    SBP_WR_IDLE = 1'b0,
    SBP_WR_RESP = 1'b1
  } sbp_wr_state_t;
endpackage : sbp_pkg
`default_nettype wire

// [hw/sbp_sync.sv]
// Two-flop synchroniser for asynchronous pin levels.
// Assumes inputs are static for at least two clocks to be seen.
`default_nettype none
module sbp_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } sbp_sync_st_t;

  sbp_sync_st_t st;
  sbp_sync_st_t next_st;

  always_comb begin
    next_st.stage1 = async_in;
    next_st.stage2 = st.stage1;
    if (!aresetn) begin
      next_st = '0;
    end
  end

  always_ff @(posedge aclk) begin
    st <= next_st;
  end

  // Only the second stage leaves this module
  assign sync_out = st.stage2;
endmodule : sbp_sync
`default_nettype wire

// [hw/sbp_pin_cell.sv]
// One port pin: output buffer, pulldown and read mux.
// Assumes the pin level arrives already synchronised.
`default_nettype none
module sbp_pin_cell (
  input wire logic direction,
  input wire logic latch,
  input wire logic level_sync,
  input wire logic pd_inhibit,
  input wire logic sw_pd_allowed,
  input wire logic alt_drive,
  input wire logic alt_level,
  output logic pin_out,
  output logic pin_oe,
  output logic pin_pulldown_en,
  output logic read_value
);
  always_comb begin
    pin_oe = direction; // R5 R6
    pin_out = alt_drive ? alt_level : latch; // R1
    // Output pins never pull down; option off leaves all pulldowns off
    pin_pulldown_en = sw_pd_allowed && !direction && !pd_inhibit; // R5 R9 R13
    read_value = direction ? latch : level_sync; // R2 R14
  end
endmodule : sbp_pin_cell
`default_nettype wire

// [hw/sbp_port.sv]
// Six-bit general-purpose port with pulldowns, AXI4-Lite register slave.
// Assumes pins and comparator levels are asynchronous; third-port
// direction bits come from logic on aclk.
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`default_nettype none
// Contract
// R1 - Output pin drives its data latch bit
// R2 - Input pin reads back sampled pin level
// R3 - Upper two data/direction bits read zero
// R4 - Reset leaves data latches unchanged
// R5 - Direction one enables driver, kills pulldown
// R6 - Direction zero disables driver, pin input
// R7 - Reset clears directions, comparator drive off
// R8 - Pulldown register write-only, reads undefined
// R9 - Inhibit zero: pulldown on for inputs
// R10 - Reset clears all inhibit bits
// R11 - Upper group inhibit controls third port high
// R12 - Lower group inhibit controls third port low
// R13 - Software pulldowns only with build option
// R14 - Output pin reads back latch value
// R15 - Data latch always writable
// R16 - Writes to upper two bits ignored
module sbp_port
  import sbp_pkg::*;
#(
  parameter logic SW_PULLDOWN_EN = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sbp_pkg::SBP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [sbp_pkg::SBP_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sbp_pkg::SBP_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [sbp_pkg::SBP_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [sbp_pkg::SBP_PORT_W-1:0] pin_in,
  output logic [sbp_pkg::SBP_PORT_W-1:0] pin_out,
  output logic [sbp_pkg::SBP_PORT_W-1:0] pin_oe,
  output logic [sbp_pkg::SBP_PORT_W-1:0] pin_pulldown_en,
  input wire logic [sbp_pkg::SBP_CMP_W-1:0] cmp_in,
  input wire logic [sbp_pkg::SBP_GROUP_W-1:0] third_port_direction_reg,
  output logic [sbp_pkg::SBP_GROUP_W-1:0] third_port_pulldown_en
);
  import sbp_pkg::*;

  typedef struct packed {
    logic [SBP_PORT_W-1:0] pin_data_bits;
    logic [SBP_PORT_W-1:0] pin_direction_bits;
    logic [SBP_PORT_W-1:0] pin_pulldown_inhibit_bits;
    logic upper_group_pulldown_inhibit;
    logic lower_group_pulldown_inhibit;
    logic [SBP_CMP_W-1:0] cmp_drive;
    logic aw_have;
    logic [SBP_ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [SBP_DATA_W-1:0] w_data;
    logic w_lane0;
    sbp_wr_state_t wr_state;
    logic [1:0] bresp;
    logic rvalid;
    logic [SBP_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } sbp_port_st_t;

  sbp_port_st_t st;
  sbp_port_st_t next_st;

  logic [SBP_PORT_W-1:0] pin_level;
  logic [SBP_CMP_W-1:0] cmp_level;
  logic [SBP_PORT_W-1:0] read_value;
  logic [SBP_PORT_W-1:0] alt_drive;
  logic [SBP_PORT_W-1:0] alt_level;

  // Word-aligned decode shared by the read and write paths
  function automatic sbp_sel_t sbp_decode(input logic [SBP_ADDR_W-1:0] addr);
    sbp_sel_t sel;
    sel = SBP_SEL_NONE;
    case ({addr[SBP_ADDR_W-1:2], 2'b00})
      SBP_PIN_DATA_OFF: sel = SBP_SEL_DATA;
      SBP_PIN_DIRECTION_OFF: sel = SBP_SEL_DIR;
      SBP_PULLDOWN_OFF: sel = SBP_SEL_PD;
      SBP_CMP_DRIVE_OFF: sel = SBP_SEL_CMP;
      SBP_PIN_LEVEL_OFF: sel = SBP_SEL_LEVEL;
      SBP_OPTIONS_OFF: sel = SBP_SEL_OPT;
      default: sel = SBP_SEL_NONE;
    endcase
    return sel;
  endfunction : sbp_decode

  sbp_sync #(
    .W(SBP_PORT_W)
  ) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(pin_in),
    .sync_out(pin_level)
  );

  sbp_sync #(
    .W(SBP_CMP_W)
  ) u_cmp_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(cmp_in),
    .sync_out(cmp_level)
  );

  // Comparators may override the latch on the upper two output pins
  always_comb begin
    alt_drive = '0;
    alt_level = '0;
    alt_drive[SBP_PORT_W-1:SBP_CMP_PIN_LO] = st.cmp_drive;
    alt_level[SBP_PORT_W-1:SBP_CMP_PIN_LO] = cmp_level;
  end

  for (genvar i = 0; i < SBP_PORT_W; i++) begin : g_pin
    sbp_pin_cell u_cell (
      .direction(st.pin_direction_bits[i]),
      .latch(st.pin_data_bits[i]),
      .level_sync(pin_level[i]),
      .pd_inhibit(st.pin_pulldown_inhibit_bits[i]),
      .sw_pd_allowed(SW_PULLDOWN_EN),
      .alt_drive(alt_drive[i]),
      .alt_level(alt_level[i]),
      .pin_out(pin_out[i]),
      .pin_oe(pin_oe[i]),
      .pin_pulldown_en(pin_pulldown_en[i]),
      .read_value(read_value[i])
    );
  end

  // Third port pulldowns, one inhibit per nibble
  always_comb begin
    for (int i = 0; i < SBP_GROUP_W; i++) begin
      if (i >= SBP_GROUP_W / 2) begin
        third_port_pulldown_en[i] = SW_PULLDOWN_EN && !third_port_direction_reg[i]
          && !st.upper_group_pulldown_inhibit; // R11 R13
      end else begin
        third_port_pulldown_en[i] = SW_PULLDOWN_EN && !third_port_direction_reg[i]
          && !st.lower_group_pulldown_inhibit; // R12 R13
      end
    end
  end

  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic wr_go;
  logic [SBP_ADDR_W-1:0] wr_addr;
  logic [SBP_DATA_W-1:0] wr_data;
  logic wr_lane0;
  sbp_sel_t wr_sel;
  sbp_sel_t rd_sel;
  logic [SBP_DATA_W-1:0] rd_word;
  logic [SBP_PORT_W-1:0] data_keep;

  // Ready only while the address or data slot is empty
  assign s_axi_awready = (st.wr_state == SBP_WR_IDLE) && !st.aw_have;
  assign s_axi_wready = (st.wr_state == SBP_WR_IDLE) && !st.w_have;
  assign s_axi_arready = !st.rvalid;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign ar_fire = s_axi_arvalid && s_axi_arready;

  assign s_axi_bvalid = (st.wr_state == SBP_WR_RESP);
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

  // Write proceeds once both halves are in, either order
  always_comb begin
    wr_go = (st.aw_have || aw_fire) && (st.w_have || w_fire);
    wr_addr = st.aw_have ? st.aw_addr : s_axi_awaddr;
    wr_data = st.w_have ? st.w_data : s_axi_wdata;
    wr_lane0 = st.w_have ? st.w_lane0 : s_axi_wstrb[0];
    wr_sel = sbp_decode(wr_addr);
  end

  // Read mux; narrow registers zero-extended
  always_comb begin
    rd_sel = sbp_decode(s_axi_araddr);
    rd_word = '0;
    case (rd_sel)
      SBP_SEL_DATA: rd_word[SBP_PORT_W-1:0] = read_value; // R2 R3 R14
      SBP_SEL_DIR: rd_word[SBP_PORT_W-1:0] = st.pin_direction_bits; // R3
      // Stored inhibit bits are not visible; reads return zero
      SBP_SEL_PD: rd_word = '0; // R8
      SBP_SEL_CMP: rd_word[SBP_CMP_W-1:0] = st.cmp_drive;
      SBP_SEL_LEVEL: rd_word[SBP_PORT_W-1:0] = pin_level;
      SBP_SEL_OPT: rd_word[0] = SW_PULLDOWN_EN;
      default: rd_word = '0;
    endcase
  end

  always_comb begin
    next_st = st;
    data_keep = st.pin_data_bits;

    if (aw_fire && !wr_go) begin
      next_st.aw_have = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (w_fire && !wr_go) begin
      next_st.w_have = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_lane0 = s_axi_wstrb[0];
    end

    case (st.wr_state)
      SBP_WR_IDLE: begin
        if (wr_go) begin
          next_st.aw_have = 1'b0;
          next_st.w_have = 1'b0;
          next_st.wr_state = SBP_WR_RESP;
          next_st.bresp = (wr_sel == SBP_SEL_NONE) ? SBP_RESP_SLVERR : SBP_RESP_OKAY;
          // Only lane 0 holds implemented bits; bits 7:6 dropped except in the pulldown register
          if (wr_lane0) begin
            case (wr_sel)
              // Stored whatever the direction bit says
              SBP_SEL_DATA: next_st.pin_data_bits = wr_data[SBP_PORT_W-1:0]; // R15 R16
              SBP_SEL_DIR: next_st.pin_direction_bits = wr_data[SBP_PORT_W-1:0]; // R16
              SBP_SEL_PD: begin
                next_st.pin_pulldown_inhibit_bits = wr_data[SBP_PORT_W-1:0]; // R9
                next_st.upper_group_pulldown_inhibit = wr_data[SBP_PD_UPPER_GRP_BIT]; // R11
                next_st.lower_group_pulldown_inhibit = wr_data[SBP_PD_LOWER_GRP_BIT]; // R12
              end
              SBP_SEL_CMP: next_st.cmp_drive = wr_data[SBP_CMP_W-1:0];
              default: begin
              end
            endcase
          end
        end
      end
      SBP_WR_RESP: begin
        if (s_axi_bready) begin
          next_st.wr_state = SBP_WR_IDLE;
        end
      end
      default: next_st.wr_state = SBP_WR_IDLE;
    endcase

    if (ar_fire) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_word;
      next_st.rresp = (rd_sel == SBP_SEL_NONE) ? SBP_RESP_SLVERR : SBP_RESP_OKAY;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    if (!aresetn) begin
      next_st = '0;
      // Latches survive reset; outputs stay off since directions clear
      next_st.pin_data_bits = data_keep; // R4
      next_st.pin_direction_bits = SBP_DIRECTION_RST; // R7
      next_st.cmp_drive = SBP_CMP_DRIVE_RST; // R7
      next_st.pin_pulldown_inhibit_bits = SBP_PD_INHIBIT_RST; // R10
      next_st.upper_group_pulldown_inhibit = SBP_PD_GROUP_RST; // R10
      next_st.lower_group_pulldown_inhibit = SBP_PD_GROUP_RST; // R10
      next_st.wr_state = SBP_WR_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    st <= next_st;
  end

  // Protection bits carry no meaning for this slave
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wstrb[3:1]};
endmodule : sbp_port
`default_nettype wire

// [sim/sbp_port_monitor.sv]
// Checker for the six-bit port: pin drive, pulldowns and register reads.
// Assumes the software pulldown option is built in and comparators idle.
`default_nettype none
module sbp_port_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sbp_pkg::SBP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [sbp_pkg::SBP_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [sbp_pkg::SBP_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [sbp_pkg::SBP_DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [sbp_pkg::SBP_PORT_W-1:0] pin_out,
  input wire logic [sbp_pkg::SBP_PORT_W-1:0] pin_oe,
  input wire logic [sbp_pkg::SBP_PORT_W-1:0] pin_pulldown_en,
  input wire logic [sbp_pkg::SBP_GROUP_W-1:0] third_port_direction_reg,
  input wire logic [sbp_pkg::SBP_GROUP_W-1:0] third_port_pulldown_en
);
  timeunit 1ns;
  timeprecision 1ps;
  import sbp_pkg::*;
  logic wr_go;
  logic rd_go;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
  assign rd_go = s_axi_arvalid && s_axi_arready;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_rst_dir;
    $rose(aresetn) |-> pin_oe == 6'h00;
  endproperty
  a_rst_dir: assert property (p_rst_dir) else $error("pins driven after reset");
  property p_rst_pd;
    $rose(aresetn) |-> pin_pulldown_en == 6'h3f
      && third_port_pulldown_en == ~third_port_direction_reg;
  endproperty
  a_rst_pd: assert property (p_rst_pd) else $error("pulldowns off after reset");
  property p_out_no_pd;
    (pin_oe & pin_pulldown_en) == 6'h00;
  endproperty
  a_out_no_pd: assert property (p_out_no_pd) else $error("pulldown on driven pin");
  property p_dir_write;
    wr_go && s_axi_awaddr == SBP_PIN_DIRECTION_OFF |=> pin_oe == $past(s_axi_wdata[5:0]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("driver enables wrong");
  property p_data_write;
    wr_go && s_axi_awaddr == SBP_PIN_DATA_OFF |=> pin_out == $past(s_axi_wdata[5:0]);
  endproperty
  a_data_write: assert property (p_data_write) else $error("pin level wrong");
  property p_pd_write;
    wr_go && s_axi_awaddr == SBP_PULLDOWN_OFF
      |=> pin_pulldown_en == (~$past(s_axi_wdata[5:0]) & ~pin_oe);
  endproperty
  a_pd_write: assert property (p_pd_write) else $error("pulldown enables wrong");
  property p_pd_read;
    rd_go && s_axi_araddr == SBP_PULLDOWN_OFF |=> s_axi_rvalid && s_axi_rdata == 32'h0;
  endproperty
  a_pd_read: assert property (p_pd_read) else $error("pulldown read not zero");
  property p_narrow_read;
    rd_go && s_axi_araddr < SBP_PULLDOWN_OFF |=> s_axi_rvalid && s_axi_rdata[31:6] == 26'h0;
  endproperty
  a_narrow_read: assert property (p_narrow_read) else $error("upper bits set");
endmodule : sbp_port_monitor
`default_nettype wire

// [sim/sbp_pin_model.sv]
// Far-side pins: external drivers, weak pulldowns and floating lines.
// Assumes the bench chooses which pins it drives and to what level.
`default_nettype none
module sbp_pin_model (
  input wire logic aclk,
  input wire logic [sbp_pkg::SBP_PORT_W-1:0] pin_out,
  input wire logic [sbp_pkg::SBP_PORT_W-1:0] pin_oe,
  input wire logic [sbp_pkg::SBP_PORT_W-1:0] pin_pulldown_en,
  input wire logic [sbp_pkg::SBP_PORT_W-1:0] ext_drive,
  input wire logic [sbp_pkg::SBP_PORT_W-1:0] ext_level,
  output logic [sbp_pkg::SBP_PORT_W-1:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  import sbp_pkg::*;
  logic float_lvl = 1'b0;
  // Floating pins wander so a missing pulldown cannot pass by luck
  always @(posedge aclk) begin
    float_lvl <= ~float_lvl;
  end
  always_comb begin
    for (int i = 0; i < SBP_PORT_W; i++) begin
      if (pin_oe[i] && ext_drive[i] && pin_out[i] !== ext_level[i]) begin
        pin_level[i] = 1'bx;
      end else if (pin_oe[i]) begin
        pin_level[i] = pin_out[i];
      end else if (ext_drive[i]) begin
        pin_level[i] = ext_level[i];
      end else if (pin_pulldown_en[i]) begin
        pin_level[i] = 1'b0;
      end else begin
        pin_level[i] = float_lvl;
      end
    end
  end
endmodule : sbp_pin_model
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the six-bit port over AXI4-Lite.
// Assumes the pin model on the far side and the default build option.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sbp_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [SBP_ADDR_W-1:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [SBP_DATA_W-1:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [SBP_PORT_W-1:0] pin_in, pin_out, pin_oe, pin_pulldown_en;
  logic [SBP_PORT_W-1:0] ext_drive = 6'h3f, ext_level = 6'h15;
  logic [SBP_GROUP_W-1:0] third_port_direction_reg = 8'h81, third_port_pulldown_en;
  // Comparator levels differ from the latch so an override shows on the pins
  logic [SBP_CMP_W-1:0] cmp_in = 2'h2;
  int miscompares = 0, n_checks = 0, cycles = 0;
  sbp_port dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in,
    .pin_out, .pin_oe, .pin_pulldown_en, .cmp_in, .third_port_direction_reg,
    .third_port_pulldown_en);
  sbp_pin_model pm (.aclk, .pin_out, .pin_oe, .pin_pulldown_en, .ext_drive, .ext_level,
    .pin_level(pin_in));
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'(er));
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, SBP_RESP_OKAY, d);
    chk(d, e);
  endtask : rdc
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : do_reset
  task automatic t_reset();
    chk(32'(pin_oe), 32'h0);
    chk(32'(pin_pulldown_en), 32'h3f);
    chk({24'h0, third_port_pulldown_en}, {24'h0, ~third_port_direction_reg});
    rdc(SBP_PIN_DIRECTION_OFF, 32'h0);
    $display("reset values done");
  endtask : t_reset
  task automatic t_output();
    wr(SBP_PIN_DATA_OFF, 32'hffff_ffea, SBP_RESP_OKAY);
    wr(SBP_PIN_DIRECTION_OFF, 32'hff, SBP_RESP_OKAY);
    chk(32'(pin_oe), 32'h3f);
    chk(32'(pin_out), 32'h2a);
    chk(32'(pin_pulldown_en), 32'h0);
    rdc(SBP_PIN_DIRECTION_OFF, 32'h3f);
    rdc(SBP_PIN_DATA_OFF, 32'h2a);
    $display("output drive done");
  endtask : t_output
  task automatic t_input();
    wr(SBP_PIN_DIRECTION_OFF, 32'h0, SBP_RESP_OKAY);
    chk(32'(pin_oe), 32'h0);
    repeat (4) @(posedge aclk);
    rdc(SBP_PIN_DATA_OFF, 32'h15);
    ext_drive <= 6'h0c;
    ext_level <= 6'h3c;
    repeat (4) @(posedge aclk);
    rdc(SBP_PIN_DATA_OFF, 32'h0c);
    wr(SBP_PIN_DIRECTION_OFF, 32'h02, SBP_RESP_OKAY);
    wr(SBP_PULLDOWN_OFF, 32'h05, SBP_RESP_OKAY);
    chk(32'(pin_pulldown_en), 32'h38);
    rdc(SBP_PULLDOWN_OFF, 32'h0);
    $display("input and pulldown done");
  endtask : t_input
  task automatic t_groups();
    logic [7:0] e;
    third_port_direction_reg <= 8'h3c;
    for (int i = 0; i < 4; i++) begin
      wr(SBP_PULLDOWN_OFF, {24'h0, 2'(i), 6'h0}, SBP_RESP_OKAY);
      e = ~third_port_direction_reg;
      if (i[0])
        e[3:0] = 4'h0;
      if (i[1])
        e[7:4] = 4'h0;
      chk({24'h0, third_port_pulldown_en}, {24'h0, e});
    end
    $display("group pulldowns done");
  endtask : t_groups
  task automatic t_midreset();
    wr(SBP_PIN_DATA_OFF, 32'h15, SBP_RESP_OKAY);
    wr(SBP_PIN_DIRECTION_OFF, 32'h3f, SBP_RESP_OKAY);
    wr(SBP_PULLDOWN_OFF, 32'hff, SBP_RESP_OKAY);
    wr(SBP_CMP_DRIVE_OFF, 32'h3, SBP_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(32'(pin_out), 32'h25);
    do_reset();
    t_reset();
    rdc(SBP_CMP_DRIVE_OFF, 32'h0);
    wr(SBP_PIN_DIRECTION_OFF, 32'h3f, SBP_RESP_OKAY);
    chk(32'(pin_out), 32'h15);
    rdc(SBP_PIN_DATA_OFF, 32'h15);
    $display("mid-run reset done");
  endtask : t_midreset
  task automatic t_bad();
    logic [31:0] d;
    wr(8'h40, 32'h1, SBP_RESP_SLVERR);
    rd(8'h40, SBP_RESP_SLVERR, d);
    chk(d, 32'h0);
    $display("unmapped access done");
  endtask : t_bad
  initial begin
    do_reset();
    t_reset();
    t_output();
    t_input();
    t_groups();
    t_midreset();
    t_bad();
    summarize();
  end
endmodule : testbench
bind sbp_port sbp_port_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_pulldown_en(pin_pulldown_en),
  .third_port_direction_reg(third_port_direction_reg),
  .third_port_pulldown_en(third_port_pulldown_en));
`default_nettype wire
